// File: hdl/lpmc_pkg.sv
package lpmc_pkg;

   // ==========================================================
   // Register map (byte addresses, APB)
   // ==========================================================
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_WAKE_EN = 8'h08;
   localparam logic [7:0] ADDR_IRQ_ST  = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_MSK = 8'h10;

   // CTRL fields
   localparam int CTRL_LVD_EN    = 0;
   localparam int CTRL_LVD_STOP  = 1;
   localparam int CTRL_RAM_EN    = 2;

   // Wake source positions
   localparam int WAKE_UART      = 0;
   localparam int WAKE_CAN       = 1;
   localparam int WAKE_SPI       = 2;
   localparam int WAKE_TWI       = 3;
   localparam int WAKE_KBI       = 4;
   localparam int WAKE_EXTIRQ    = 5;
   localparam int WAKE_W         = 6;

   // Interrupt status fields
   localparam int IRQ_WAKE       = 0;
   localparam int IRQ_ACK_ERR    = 1;
   localparam int IRQ_W          = 2;

   // Reset values
   localparam logic [2:0] CTRL_RST       = 3'h5;
   localparam logic [5:0] WAKE_EN_RST    = 6'h3F;

   // Timing: Stop acknowledge timeout in low-power oscillator cycles
   localparam int ACK_TIMEOUT_LPO = 1025;
   localparam int ACK_CNT_W       = 11;

   // Modes
   typedef enum logic [1:0]
   {
      MODE_RUN  = 2'b00,
      MODE_WAIT = 2'b01,
      MODE_STOP = 2'b10
   } lpmc_mode_e;

   typedef enum logic [2:0]
   {
      ST_RUN     = 3'b000,
      ST_WAIT    = 3'b001,
      ST_STOPREQ = 3'b010,
      ST_STOP    = 3'b011,
      ST_ERRRST  = 3'b100
   } lpmc_state_e;

endpackage

// File: hdl/lpmc_sync.sv
`timescale 1ns/100ps
module lpmc_sync
   import lpmc_pkg::*;
#(
   parameter int W = 1
)
(
   input  wire logic         clk,   // Core clock
   input  wire logic         rst,   // Synchronous reset
   input  wire logic [W-1:0] din,   // Asynchronous levels
   output logic      [W-1:0] dout   // Synchronised levels
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;

endmodule

// File: hdl/lpmc_ack_timer.sv
`timescale 1ns/100ps
module lpmc_ack_timer
   import lpmc_pkg::*;
#(
   parameter int LIMIT = ACK_TIMEOUT_LPO
)
(
   input  wire logic clk,       // Core clock
   input  wire logic rst,       // Synchronous reset
   input  wire logic run,       // Count while high, clear while low
   input  wire logic lpo_tick,  // One pulse per oscillator rising edge
   output logic      expired    // Limit reached
);

   logic [ACK_CNT_W-1:0] cnt_q;
   logic [ACK_CNT_W-1:0] cnt_d;

   // Saturates so a late acknowledge can never wrap into a false pass
   assign cnt_d = !run ? '0 :
                  (lpo_tick && cnt_q != ACK_CNT_W'(LIMIT)) ? cnt_q + 1'b1 : cnt_q;
   assign expired = (cnt_q == ACK_CNT_W'(LIMIT));

   always_ff @(posedge clk)
   begin
      if (rst)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

endmodule

// File: hdl/lpmc_top.sv
`timescale 1ns/100ps
// Behaviour
// - After reset: Run mode, regulator fully on, core clocks running.
// - Only the core's wait-for-interrupt request starts a low-power entry.
// - An enabled interrupt returns Wait or Stop to Run.
// - Wait stops the core clock, keeps interrupt controller and peripherals clocked.
// - Wait keeps system and bus clocks running, regulator in full regulation.
// - Stop disables nested controller, stops peripheral clocks, async controller wakes.
// - Stop puts regulator in standby; detector stays on only if enabled.
// - Stop is static; all register contents are retained.
// - Pad states are held in every mode.
// - RAM enable low gates RAM clock; RAM clock may run in Wait.
// - Serial and CAN receive edges wake the chip from Stop.
// - SPI slave reception wakes the chip from Stop.
// - Two-wire own-address match wakes the chip from Stop.
// - Keyboard and external pin interrupts wake the chip from Stop.
// - Missing Stop acknowledge within 1025 oscillator cycles issues a system reset.
// - Stop entry turns detector off unless stop-enable set or debug active.
module lpmc_top
   import lpmc_pkg::*;
(
   input  wire logic        CORE_CLK,      // 20 MHz core clock
   input  wire logic        SYS_RST,       // Synchronous reset, active high
   input  wire logic        PSEL,          // APB select
   input  wire logic        PENABLE,       // APB access phase
   input  wire logic        PWRITE,        // APB direction
   input  wire logic [7:0]  PADDR,         // APB byte address
   input  wire logic [31:0] PWDATA,        // APB write data
   output logic      [31:0] PRDATA,        // APB read data
   output logic             PREADY,        // APB ready
   output logic             PSLVERR,       // APB error on unmapped address
   input  wire logic        WFI_REQ,       // Core executed wait_for_interrupt_instr (pulse)
   input  wire logic        SLEEP_DEEP,    // Core deep sleep select
   input  wire logic        IRQ_PENDING,   // Enabled interrupt pending at core
   input  wire logic        STOP_ACK_ALL,  // All modules acknowledge Stop
   input  wire logic        LPO_CLK_IN,    // low_power_osc clock, asynchronous
   input  wire logic        DEBUG_ACTIVE,  // Serial-wire debug active
   input  wire logic [5:0]  WAKE_SRC,      // Peripheral wake requests, asynchronous
   output logic             CORE_CLK_EN,   // Core clock gate enable
   output logic             NESTED_IRQ_CONTROLLER_EN,       // nested_irq_controller enabled
   output logic             ASYNC_WAKEUP_IRQ_CONTROLLER_EN,       // async_wakeup_irq_controller armed
   output logic             PERIPH_CLK_EN, // Peripheral clock enable
   output logic             BUS_CLK_EN,    // Bus and system clock enable
   output logic             REG_FULL,      // Regulator full regulation (0 = standby)
   output logic             LVD_ON,        // low_voltage_detector enable
   output logic             STOP_REQ,      // Stop entry request to modules
   output logic             RAM_EN,        // RAM enable, low gates RAM clock
   output logic             PAD_HOLD,      // Pad state hold, always asserted
   output logic             WAKE_ARM,      // Peripheral Stop wake logic armed
   output logic             SYS_RST_REQ,   // System reset request (stop_ack_error)
   output logic             IRQ            // Level interrupt
);

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   logic [7:0] async_in;
   logic [7:0] async_s;
   logic       lpo_s;
   logic       ack_s;
   logic [5:0] wake_s;

   assign async_in = {STOP_ACK_ALL, LPO_CLK_IN, WAKE_SRC};

   lpmc_sync #(.W(8)) u_sync
   (
      .clk  (CORE_CLK),
      .rst  (SYS_RST),
      .din  (async_in),
      .dout (async_s)
   );

   assign wake_s = async_s[5:0];
   assign lpo_s  = async_s[6];
   assign ack_s  = async_s[7];

   logic lpo_prev_q;
   logic lpo_tick;
   assign lpo_tick = lpo_s & ~lpo_prev_q;

   // ==========================================================
   // Registers
   // ==========================================================
   logic [2:0]       ctrl_q;
   logic [WAKE_W-1:0] wake_en_q;
   logic [IRQ_W-1:0] irq_st_q;
   logic [IRQ_W-1:0] irq_st_d;
   logic [IRQ_W-1:0] irq_msk_q;
   lpmc_state_e      state_q;
   lpmc_state_e      state_d;
   logic             ack_expired;

   // ==========================================================
   // APB slave, zero wait states
   // ==========================================================
   logic        acc;
   logic        wr;
   logic        hit_ctrl;
   logic        hit_stat;
   logic        hit_wake;
   logic        hit_ist;
   logic        hit_msk;
   logic        mapped;
   logic [31:0] rdata_d;

   assign acc      = PSEL & PENABLE;
   assign wr       = acc & PWRITE;
   assign hit_ctrl = (PADDR == ADDR_CTRL);
   assign hit_stat = (PADDR == ADDR_STATUS);
   assign hit_wake = (PADDR == ADDR_WAKE_EN);
   assign hit_ist  = (PADDR == ADDR_IRQ_ST);
   assign hit_msk  = (PADDR == ADDR_IRQ_MSK);
   assign mapped   = hit_ctrl | hit_stat | hit_wake | hit_ist | hit_msk;

   assign rdata_d = hit_ctrl ? {29'h0, ctrl_q} :
                    hit_stat ? {27'h0, LVD_ON, REG_FULL, state_q} :
                    hit_wake ? {26'h0, wake_en_q} :
                    hit_ist  ? {30'h0, irq_st_q} :
                    hit_msk  ? {30'h0, irq_msk_q} : 32'h0;

   // Ready is tied high so the answer comes in the access cycle
   assign PREADY  = 1'b1;
   assign PSLVERR = acc & ~mapped;
   assign PRDATA  = rdata_d;

   // ==========================================================
   // Mode sequencer
   // ==========================================================
   logic wake_hit;
   assign wake_hit = |(wake_s & wake_en_q);

   logic stop_wake;
   assign stop_wake = IRQ_PENDING | wake_hit;

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_RUN:
            if (WFI_REQ)
               state_d = SLEEP_DEEP ? ST_STOPREQ : ST_WAIT;
         ST_WAIT:
            if (IRQ_PENDING)
               state_d = ST_RUN;
         ST_STOPREQ:
            if (stop_wake)
               state_d = ST_RUN;
            else if (ack_s)
               state_d = ST_STOP;
            else if (ack_expired)
               state_d = ST_ERRRST;
         ST_STOP:
            if (stop_wake)
               state_d = ST_RUN;
         ST_ERRRST:
            state_d = ST_ERRRST;  // Held until the chip reset lands
         default:
            state_d = ST_RUN;
      endcase
   end

   lpmc_ack_timer u_ack_timer
   (
      .clk      (CORE_CLK),
      .rst      (SYS_RST),
      .run      (state_q == ST_STOPREQ),
      .lpo_tick (lpo_tick),
      .expired  (ack_expired)
   );

   // ==========================================================
   // Interrupt status: set wins over write-one-to-clear
   // ==========================================================
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;
   assign irq_set[IRQ_WAKE]    = (state_q == ST_STOP || state_q == ST_WAIT) && state_d == ST_RUN;
   assign irq_set[IRQ_ACK_ERR] = (state_q == ST_STOPREQ) && (state_d == ST_ERRRST);
   assign irq_clr              = (wr && hit_ist) ? PWDATA[IRQ_W-1:0] : '0;
   assign irq_st_d             = (irq_st_q & ~irq_clr) | irq_set;

   // ==========================================================
   // Control outputs from the next state
   // ==========================================================
   logic in_stop_d;
   logic in_wait_d;
   logic lvd_d;
   assign in_stop_d = (state_d == ST_STOP);
   assign in_wait_d = (state_d == ST_WAIT);
   // Detector off in Stop unless stop-enable or debug keeps it alive
   assign lvd_d = ctrl_q[CTRL_LVD_EN] &
                  (~in_stop_d | ctrl_q[CTRL_LVD_STOP] | DEBUG_ACTIVE);

   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         state_q       <= ST_RUN;
         lpo_prev_q    <= 1'b0;
         ctrl_q        <= CTRL_RST;
         wake_en_q     <= WAKE_EN_RST;
         irq_st_q      <= '0;
         irq_msk_q     <= '0;
         CORE_CLK_EN   <= 1'b1;
         NESTED_IRQ_CONTROLLER_EN       <= 1'b1;
         ASYNC_WAKEUP_IRQ_CONTROLLER_EN       <= 1'b0;
         PERIPH_CLK_EN <= 1'b1;
         BUS_CLK_EN    <= 1'b1;
         REG_FULL      <= 1'b1;
         LVD_ON        <= 1'b1;
         STOP_REQ      <= 1'b0;
         RAM_EN        <= 1'b1;
         PAD_HOLD      <= 1'b1;
         WAKE_ARM      <= 1'b0;
         SYS_RST_REQ   <= 1'b0;
         IRQ           <= 1'b0;
      end
      else
      begin
         state_q       <= state_d;
         lpo_prev_q    <= lpo_s;
         if (wr && hit_ctrl)
            ctrl_q <= PWDATA[2:0];
         if (wr && hit_wake)
            wake_en_q <= PWDATA[WAKE_W-1:0];
         if (wr && hit_msk)
            irq_msk_q <= PWDATA[IRQ_W-1:0];
         irq_st_q      <= irq_st_d;
         // Core halts in both sleep levels
         CORE_CLK_EN   <= (state_d == ST_RUN) | (state_d == ST_STOPREQ);
         NESTED_IRQ_CONTROLLER_EN       <= ~in_stop_d;
         ASYNC_WAKEUP_IRQ_CONTROLLER_EN       <= in_stop_d;
         PERIPH_CLK_EN <= ~in_stop_d;
         BUS_CLK_EN    <= ~in_stop_d;
         REG_FULL      <= ~in_stop_d;
         LVD_ON        <= lvd_d;
         STOP_REQ      <= (state_d == ST_STOPREQ) | in_stop_d;
         // RAM clock follows software enable outside Stop and is forced off in Stop; it is allowed to keep running in Wait
         RAM_EN        <= ctrl_q[CTRL_RAM_EN] & ~in_stop_d;
         PAD_HOLD      <= 1'b1;
         WAKE_ARM      <= in_stop_d;
         SYS_RST_REQ   <= (state_d == ST_ERRRST);
         IRQ           <= |(irq_st_d & irq_msk_q);
      end
   end
   // Stop only gates clocks; no register here is cleared on Stop entry or exit
   logic unused_wait;
   assign unused_wait = in_wait_d;

   // ==========================================================
   // Assertions
   // ==========================================================
   sequence enter_stop_s;
      state_q == ST_STOPREQ ##1 state_q == ST_STOP;
   endsequence

   reset_run_a: assert property (@(posedge CORE_CLK) $fell(SYS_RST) |-> CORE_CLK_EN && REG_FULL)
      else $error("not in run after reset");

   wfi_only_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (state_q == ST_RUN && !WFI_REQ) |=> state_q == ST_RUN)
      else $error("left run without request");

   deep_select_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (state_q == ST_RUN && WFI_REQ) |=> state_q == (SLEEP_DEEP ? ST_STOPREQ : ST_WAIT))
      else $error("wrong sleep level chosen");

   wait_wake_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (state_q == ST_WAIT && IRQ_PENDING) |=> state_q == ST_RUN ##1 CORE_CLK_EN)
      else $error("wait not ended by interrupt");

   wait_clocks_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      $past(state_q) == ST_WAIT && state_q == ST_WAIT |-> !CORE_CLK_EN && NESTED_IRQ_CONTROLLER_EN && PERIPH_CLK_EN && BUS_CLK_EN && REG_FULL)
      else $error("wait clocking wrong");

   stop_gating_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      enter_stop_s |=> !NESTED_IRQ_CONTROLLER_EN && ASYNC_WAKEUP_IRQ_CONTROLLER_EN && !PERIPH_CLK_EN && !REG_FULL)
      else $error("stop gating wrong");

   stop_lvd_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (enter_stop_s ##0 !ctrl_q[CTRL_LVD_STOP] && !DEBUG_ACTIVE) |=> !LVD_ON)
      else $error("detector left on in stop");

   pad_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) PAD_HOLD)
      else $error("pads released");

   ack_err_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (state_q == ST_STOPREQ && ack_expired && !ack_s && !stop_wake) |=> ##1 SYS_RST_REQ)
      else $error("no reset on missing ack");

endmodule

// File: testbench/lpmc_periph_model.sv
`timescale 1ns/100ps
// ==========================================================
// Far side: module Stop acknowledge and oscillator
// ==========================================================
module lpmc_periph_model
(
   input  wire logic       clk,      // Core clock
   input  wire logic       stop_req, // Stop entry request from the controller
   input  wire logic       ack_en,   // Low models a module that never acknowledges
   input  wire logic [3:0] ack_dly,  // Cycles of request before acknowledge
   output logic            stop_ack, // All modules acknowledge
   output logic            lpo_clk   // Free running oscillator
);
   int cnt;

   initial
   begin
      cnt      = 0;
      stop_ack = 1'b0;
      lpo_clk  = 1'b0;
   end

   // Runs in every mode; far faster than the real one so the timeout fits the run
   always #100 lpo_clk = ~lpo_clk;

   // Acknowledge only while asked, and drop it once the request is gone
   always @(posedge clk)
   begin
      cnt      <= stop_req ? cnt + 1 : 0;
      stop_ack <= ack_en && stop_req && (cnt >= int'(ack_dly));
   end
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import lpmc_pkg::*;
   logic        clk, rst, psel, penable, pwrite, sleep_req, sleep_deep, irq_pend, dbg, ack_en;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, seed;
   logic [5:0]  wake_src;
   logic [3:0]  ack_dly;
   logic        pready, pslverr, stop_ack, lpo_clk, core_en, nested_en, async_wk_en, periph_en, bus_en;
   logic        reg_full, lvdet_on, stop_req, ram_en, pad_hold, wake_arm, sys_rst_req, irq;
   logic [9:0]  obs;
   logic [2:0]  flags, c;
   int          fails, checks, cyc;

   assign obs   = {core_en, nested_en, async_wk_en, periph_en, bus_en, reg_full, lvdet_on, ram_en, wake_arm, pad_hold};
   assign flags = {sys_rst_req, async_wk_en, core_en};

   lpmc_top dut_u (.CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .WFI_REQ(sleep_req), .SLEEP_DEEP(sleep_deep), .IRQ_PENDING(irq_pend), .STOP_ACK_ALL(stop_ack),
      .LPO_CLK_IN(lpo_clk), .DEBUG_ACTIVE(dbg), .WAKE_SRC(wake_src), .CORE_CLK_EN(core_en),
      .NESTED_IRQ_CONTROLLER_EN(nested_en), .ASYNC_WAKEUP_IRQ_CONTROLLER_EN(async_wk_en), .PERIPH_CLK_EN(periph_en), .BUS_CLK_EN(bus_en),
      .REG_FULL(reg_full), .LVD_ON(lvdet_on), .STOP_REQ(stop_req), .RAM_EN(ram_en),
      .PAD_HOLD(pad_hold), .WAKE_ARM(wake_arm), .SYS_RST_REQ(sys_rst_req), .IRQ(irq));

   lpmc_periph_model part_u (.clk(clk), .stop_req(stop_req), .ack_en(ack_en), .ack_dly(ack_dly),
      .stop_ack(stop_ack), .lpo_clk(lpo_clk));

   // ==========================================================
   // Clock, timeout and verdict
   // ==========================================================
   always #25 clk = ~clk;

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 9000)
      begin
         fails++;
         end_sim();
      end
   end

   task end_sim;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction

   // Mode 0 Run, 1 Wait, 2 Stop
   function automatic logic [9:0] exp_outs(input int m, input logic [2:0] cr, input logic d);
      case (m)
         0: exp_outs = {1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, cr[0], cr[2], 1'b0, 1'b1};
         1: exp_outs = {1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, cr[0], cr[2], 1'b0, 1'b1};
         default: exp_outs = {1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, cr[0] & (cr[1] | d), 1'b0, 1'b1, 1'b1};
      endcase
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_outs(input int m);
      @(negedge clk);
      chk({22'h0, obs}, {22'h0, exp_outs(m, c, dbg)});
   endtask

   task automatic wait_bit(input int b, input logic v, input int maxc);
      int n;
      n = 0;
      while (flags[b] !== v && n < maxc)
      begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, flags[b]}, {31'h0, v});
   endtask

   // Waits for pready however long it takes; only the bench timeout ends a hang
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(a, 1'b1, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] r;
      logic        e;
      apb(a, 1'b0, 32'h0, r, e);
      chk(r, exp);
      chk({31'h0, e}, {31'h0, experr});
   endtask

   task automatic sleep(input logic deep);
      @(posedge clk);
      sleep_req  <= 1'b1;
      sleep_deep <= deep;
      @(posedge clk);
      sleep_req  <= 1'b0;
   endtask

   task automatic do_reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   initial
   begin
      {clk, rst, psel, penable, pwrite, sleep_req, sleep_deep, irq_pend, dbg} = 9'h0;
      {paddr, pwdata, wake_src} = 46'h0;
      {ack_en, ack_dly, fails, checks, cyc} = 0;
      ack_en = 1'b1;
      rst    = 1'b1;
      seed   = 32'h0001403A;
      c      = CTRL_RST;
      do_reset();
      chk_outs(0);
      rd(ADDR_CTRL, 32'h5, 1'b0);
      rd(ADDR_WAKE_EN, 32'h3F, 1'b0);
      rd(ADDR_STATUS, 32'h18, 1'b0);
      rd(8'h14, 32'h0, 1'b1);
      // Everything except the sleep request must leave Run alone
      repeat (8)
      begin
         @(posedge clk);
         seed = lfsr(seed);
         irq_pend   <= seed[0];
         sleep_deep <= seed[1];
         wake_src   <= seed[7:2];
      end
      @(posedge clk);
      irq_pend <= 1'b0;
      wake_src <= 6'h0;
      chk_outs(0);
      wr(ADDR_IRQ_MSK, 32'h3);
      sleep(1'b0);
      wait_bit(0, 1'b0, 8);
      chk_outs(1);
      irq_pend <= 1'b1;
      wait_bit(0, 1'b1, 8);
      irq_pend <= 1'b0;
      chk_outs(0);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      wr(ADDR_IRQ_ST, 32'h1);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      for (int i = 0; i < 6; i++)
      begin
         seed = lfsr(seed);
         c = {1'b1, seed[1:0]};
         dbg     <= seed[2];
         ack_dly <= seed[6:3];
         wr(ADDR_CTRL, {29'h0, c});
         wr(ADDR_WAKE_EN, 32'h1 << i);
         sleep(1'b1);
         wait_bit(1, 1'b1, 40);
         chk_outs(2);
         wake_src <= 6'h1 << ((i + 1) % 6);
         repeat (6) @(posedge clk);
         chk({31'h0, async_wk_en}, 32'h1);
         wake_src <= 6'h1 << i;
         wait_bit(0, 1'b1, 8);
         wake_src <= 6'h0;
         chk_outs(0);
         rd(ADDR_CTRL, {29'h0, c}, 1'b0);
         wr(ADDR_IRQ_ST, 32'h3);
      end
      ack_en <= 1'b0;
      sleep(1'b1);
      repeat (4) @(posedge clk);
      chk({31'h0, stop_req}, 32'h1);
      repeat (4000) @(posedge clk);
      chk({31'h0, sys_rst_req}, 32'h0);
      wait_bit(2, 1'b1, 400);
      do_reset();
      c = CTRL_RST;
      chk_outs(0);
      end_sim();
   end
endmodule
